// ===== inc/amp_seq_pkg.sv
// Constants and types shared by the amplifier mode and fault sequencer
package amp_seq_pkg;
	localparam int          NUM_CH         = 4;
	localparam int          CLK_HZ         = 10000000;
	localparam int          RETRY_MS       = 15;
	localparam int          RETRY_CYC      = (CLK_HZ / 1000) * RETRY_MS;
	localparam int          RAMP_CYC_DEF   = 1000;
	// Cycles a retried channel runs to let a returning short show past the synchroniser
	localparam int          TEST_CYC       = 4;
	// Register byte offsets
	localparam logic [7:0]  CTRL_OFS       = 8'h00;
	localparam logic [7:0]  STAT_OFS       = 8'h04;
	localparam logic [7:0]  FAULT_OFS      = 8'h08;
	// Control field positions
	localparam int          AMP_ON_POS     = 0;
	localparam int          EFF_EN_POS     = 1;
	localparam int          FOUR_CH_POS    = 2;
	localparam int          LOAD_4OHM_POS  = 3;
	localparam int          FAULT_INDICATOR_PIN_SEL_POS   = 4;
	localparam int          CH_DIS_POS     = 8;
	localparam logic [31:0] CTRL_RST       = 32'h0000_0000;
	localparam logic [1:0]  RESP_OKAY      = 2'h0;
	localparam logic [1:0]  RESP_SLVERR    = 2'h2;
	typedef enum logic [1:0] {AMP_OFF, AMP_START, AMP_RUN, AMP_STOP} amp_state_t;
endpackage

// ===== verilog/amp_mode_fault_sequencer.sv
// Mode gating, power-on reset and short-circuit retry sequencer of a quad BTL amplifier
//
// The implementer's own choices: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
// How it works
// - Start-up and shut-down always in plain BTL
// - Software control bit enables efficiency mode
// - Control bit selects paired or four-channel sharing
// - Load bit picks 2 or 4 ohm threshold
// - Supply below 10 V disables efficiency
// - Legacy mode: four-channel, 2 ohm levels
// - Power-on reset outside legacy mode clears control and channel latches (not fault flags), pulls indicator
// - Amp-on bit clears flag, releases pin, starts
// - Legacy: off below 6 V, restart with standby
// - Short switches off only its channel
// - Fault register reports channel and short type
// - Select bit zero drives indicator on short
// - Ground or supply short blocks restart
// - Load short retried every 15 ms
// - Retries run one channel at a time
// - Software disable keeps shorted channel off
// - Switch closed below half supply in efficiency mode, else open
// - Grounded address pin selects legacy mode
module amp_mode_fault_sequencer
	import amp_seq_pkg::*;
#(
	parameter int RETRY_CYCLES = RETRY_CYC,
	parameter int RAMP_CYCLES  = RAMP_CYC_DEF
)(
	input  wire logic              sys_clk_i,
	input  wire logic              srst_i,
	input  wire logic [7:0]        s_axi_awaddr_i,
	input  wire logic              s_axi_awvalid_i,
	output logic                   s_axi_awready_o,
	input  wire logic [31:0]       s_axi_wdata_i,
	input  wire logic [3:0]        s_axi_wstrb_i,
	input  wire logic              s_axi_wvalid_i,
	output logic                   s_axi_wready_o,
	output logic [1:0]             s_axi_bresp_o,
	output logic                   s_axi_bvalid_o,
	input  wire logic              s_axi_bready_i,
	input  wire logic [7:0]        s_axi_araddr_i,
	input  wire logic              s_axi_arvalid_i,
	output logic                   s_axi_arready_o,
	output logic [31:0]            s_axi_rdata_o,
	output logic [1:0]             s_axi_rresp_o,
	output logic                   s_axi_rvalid_o,
	input  wire logic              s_axi_rready_i,
	input  wire logic              por_i,
	input  wire logic              address_select_pin_i,
	input  wire logic              standby_control_pin_i,
	input  wire logic              supply_below_6v_i,
	input  wire logic              supply_below_10v_i,
	input  wire logic [NUM_CH-1:0] out_above_half_i,
	input  wire logic [NUM_CH-1:0] short_gnd_i,
	input  wire logic [NUM_CH-1:0] short_sup_i,
	input  wire logic [NUM_CH-1:0] short_load_i,
	output logic [NUM_CH-1:0]      ch_enable_o,
	output logic                   eff_mode_o,
	output logic                   eff_four_ch_o,
	output logic                   eff_level_4ohm_o,
	output logic [NUM_CH-1:0]      eff_switch_closed_o,
	output logic                   fault_indicator_pin_o,
	output logic                   fault_indicator_pin_oe_o
);
	import amp_seq_pkg::*;

	// Pin and analog comparator inputs pass two flip-flops before use
	logic [5+4*NUM_CH-1:0] sync1, sync2;
	always_ff @(posedge sys_clk_i)
	begin
		sync1 <= {por_i, address_select_pin_i, standby_control_pin_i, supply_below_6v_i,
			supply_below_10v_i, out_above_half_i, short_gnd_i, short_sup_i, short_load_i};
		sync2 <= sync1;
	end
	logic              por_s, address_select_pin_s, stb_s, low6_s, low10_s;
	logic [NUM_CH-1:0] above_s, sgnd_s, ssup_s, sload_s;
	assign {por_s, address_select_pin_s, stb_s, low6_s, low10_s, above_s, sgnd_s, ssup_s, sload_s} =
		sync2;

	// Grounded address pin means standalone operation
	logic legacy;
	assign legacy = ~address_select_pin_s;

	// Register state
	logic [31:0] ctrl, next_ctrl;
	logic        por_flag, next_por_flag;
	logic        aw_hold, next_aw_hold, w_hold, next_w_hold;
	logic [7:0]  aw_addr, next_aw_addr;
	logic [31:0] w_data, next_w_data;
	logic [3:0]  w_strb, next_w_strb;
	logic        bvalid, next_bvalid, rvalid, next_rvalid;
	logic [1:0]  bresp, next_bresp, rresp, next_rresp;
	logic [31:0] rdata, next_rdata;

	// Channel state
	amp_state_t        amp_st, next_amp_st;
	logic [31:0]       ramp_cnt, next_ramp_cnt;
	logic [NUM_CH-1:0] ch_off, next_ch_off;
	logic [NUM_CH-1:0] load_pend, next_load_pend;
	logic [NUM_CH-1:0] retry_ch, next_retry_ch;
	logic [NUM_CH-1:0] retry_last, next_retry_last;
	logic [31:0]       retry_cnt, next_retry_cnt;
	logic [NUM_CH-1:0] fault_gnd, next_fault_gnd, fault_sup, next_fault_sup;
	logic [NUM_CH-1:0] fault_load, next_fault_load;

	logic              amp_req;
	logic [NUM_CH-1:0] sw_dis;
	assign sw_dis  = ctrl[CH_DIS_POS +: NUM_CH];
	assign amp_req = legacy ? (stb_s & ~low6_s) : (ctrl[AMP_ON_POS] & ~low6_s);

	function automatic logic [NUM_CH-1:0] lowest_bit(input logic [NUM_CH-1:0] v);
		logic [NUM_CH-1:0] r;
		r = '0;
		for (int i = NUM_CH - 1; i >= 0; i--)
			if (v[i])
				r = '0 | (NUM_CH'(1) << i);
		return r;
	endfunction

	// Rotate upward from the last channel served so no shorted channel starves
	function automatic logic [NUM_CH-1:0] pick_next(input logic [NUM_CH-1:0] pend,
		input logic [NUM_CH-1:0] last);
		logic [NUM_CH-1:0] above;
		above = pend & ~((last << 1) - NUM_CH'(1));
		return (above != '0) ? lowest_bit(above) : lowest_bit(pend);
	endfunction

	logic wr_fire, rd_fire;
	assign wr_fire = aw_hold & w_hold & ~bvalid;
	assign rd_fire = s_axi_arvalid_i & ~rvalid;

	always_comb
	begin
		next_ctrl     = ctrl;
		next_por_flag = por_flag;
		next_aw_hold  = aw_hold;
		next_aw_addr  = aw_addr;
		next_w_hold   = w_hold;
		next_w_data   = w_data;
		next_w_strb   = w_strb;
		next_bvalid   = bvalid & ~s_axi_bready_i;
		next_bresp    = bresp;
		next_rvalid   = rvalid & ~s_axi_rready_i;
		next_rresp    = rresp;
		next_rdata    = rdata;
		if (s_axi_awvalid_i & ~aw_hold)
		begin
			next_aw_hold = 1'b1;
			next_aw_addr = s_axi_awaddr_i;
		end
		if (s_axi_wvalid_i & ~w_hold)
		begin
			next_w_hold = 1'b1;
			next_w_data = s_axi_wdata_i;
			next_w_strb = s_axi_wstrb_i;
		end
		if (wr_fire)
		begin
			next_aw_hold = 1'b0;
			next_w_hold  = 1'b0;
			next_bvalid  = 1'b1;
			next_bresp   = RESP_OKAY;
			if ({aw_addr[7:2], 2'b00} == CTRL_OFS)
			begin
				for (int b = 0; b < 4; b++)
					if (w_strb[b])
						next_ctrl[8*b +: 8] = w_data[8*b +: 8];
			end
			else if ({aw_addr[7:2], 2'b00} != STAT_OFS && {aw_addr[7:2], 2'b00} != FAULT_OFS)
				next_bresp = RESP_SLVERR;
		end
		if (rd_fire)
		begin
			next_rvalid = 1'b1;
			next_rresp  = RESP_OKAY;
			case ({s_axi_araddr_i[7:2], 2'b00})
				CTRL_OFS:  next_rdata = ctrl;
				STAT_OFS:  next_rdata = {26'h0, legacy, ~low10_s, eff_mode_o,
					amp_st == AMP_RUN, amp_st != AMP_OFF, por_flag};
				FAULT_OFS: next_rdata = {12'h0, fault_load, 4'h0, fault_sup,
					4'h0, fault_gnd};
				default:
				begin
					next_rdata = 32'h0000_0000;
					next_rresp = RESP_SLVERR;
				end
			endcase
		end
		if (~legacy && ctrl[AMP_ON_POS] && amp_st == AMP_OFF)
			next_por_flag = 1'b0;
		if (por_s && ~legacy)
		begin
			next_ctrl     = CTRL_RST;
			next_por_flag = 1'b1;
		end
	end

	always_comb
	begin
		next_amp_st     = amp_st;
		next_ramp_cnt   = ramp_cnt;
		next_ch_off     = ch_off;
		next_load_pend  = load_pend;
		next_retry_ch   = retry_ch;
		next_retry_cnt  = retry_cnt;
		next_retry_last = retry_last;
		next_fault_gnd  = fault_gnd | sgnd_s;
		next_fault_sup  = fault_sup | ssup_s;
		next_fault_load = fault_load | sload_s;
		case (amp_st)
			AMP_OFF:
				if (amp_req && !(por_flag && ~legacy))
				begin
					next_amp_st   = AMP_START;
					next_ramp_cnt = '0;
				end
			AMP_START, AMP_STOP:
				if (ramp_cnt == 32'(RAMP_CYCLES - 1))
					next_amp_st = (amp_st == AMP_START) ? AMP_RUN : AMP_OFF;
				else
					next_ramp_cnt = ramp_cnt + 32'd1;
			AMP_RUN:
				if (!amp_req)
				begin
					next_amp_st   = AMP_STOP;
					next_ramp_cnt = '0;
				end
			default: next_amp_st = AMP_OFF;
		endcase
		// Only shorted or software-disabled channels go off
		next_ch_off    = ch_off | sgnd_s | ssup_s | sload_s | sw_dis;
		next_load_pend = (load_pend | sload_s) & ~sw_dis;
		// Persistent ground or supply shorts keep the channel off
		for (int i = 0; i < NUM_CH; i++)
			if (ch_off[i] && !sgnd_s[i] && !ssup_s[i] && !sload_s[i] && !sw_dis[i]
				&& !load_pend[i])
			begin
				next_ch_off[i]    = 1'b0;
				next_fault_gnd[i] = sgnd_s[i];
				next_fault_sup[i] = ssup_s[i];
			end
		// The channel stays off for the interval, then runs a short test window
		if (retry_ch == '0)
		begin
			if ((load_pend & ~sw_dis) != '0)
			begin
				next_retry_ch  = pick_next(load_pend & ~sw_dis, retry_last);
				next_retry_cnt = '0;
			end
		end
		else if (retry_cnt < 32'(RETRY_CYCLES))
			next_retry_cnt = retry_cnt + 32'd1;
		else if ((sload_s & retry_ch) != '0)
		begin
			next_retry_ch   = '0;
			next_retry_cnt  = '0;
			next_retry_last = retry_ch;
		end
		else if (retry_cnt == 32'(RETRY_CYCLES + TEST_CYC - 1))
		begin
			next_load_pend  = next_load_pend & ~retry_ch;
			next_fault_load = next_fault_load & ~retry_ch;
			next_retry_ch   = '0;
			next_retry_last = retry_ch;
		end
		else
			next_retry_cnt = retry_cnt + 32'd1;
		if ((sw_dis & retry_ch) != '0)
			next_retry_ch = '0;
		if (por_s && ~legacy)
		begin
			next_amp_st    = AMP_OFF;
			next_ch_off    = '0;
			next_load_pend = '0;
			next_retry_ch  = '0;
		end
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (srst_i)
		begin
			ctrl       <= CTRL_RST;
			por_flag   <= 1'b1;
			aw_hold    <= 1'b0;
			aw_addr    <= '0;
			w_hold     <= 1'b0;
			w_data     <= '0;
			w_strb     <= '0;
			bvalid     <= 1'b0;
			bresp      <= RESP_OKAY;
			rvalid     <= 1'b0;
			rresp      <= RESP_OKAY;
			rdata      <= '0;
			amp_st     <= AMP_OFF;
			ramp_cnt   <= '0;
			ch_off     <= '0;
			load_pend  <= '0;
			retry_ch   <= '0;
			retry_last <= '0;
			retry_cnt  <= '0;
			fault_gnd  <= '0;
			fault_sup  <= '0;
			fault_load <= '0;
		end
		else
		begin
			ctrl       <= next_ctrl;
			por_flag   <= next_por_flag;
			aw_hold    <= next_aw_hold;
			aw_addr    <= next_aw_addr;
			w_hold     <= next_w_hold;
			w_data     <= next_w_data;
			w_strb     <= next_w_strb;
			bvalid     <= next_bvalid;
			bresp      <= next_bresp;
			rvalid     <= next_rvalid;
			rresp      <= next_rresp;
			rdata      <= next_rdata;
			amp_st     <= next_amp_st;
			ramp_cnt   <= next_ramp_cnt;
			ch_off     <= next_ch_off;
			load_pend  <= next_load_pend;
			retry_ch   <= next_retry_ch;
			retry_last <= next_retry_last;
			retry_cnt  <= next_retry_cnt;
			fault_gnd  <= next_fault_gnd;
			fault_sup  <= next_fault_sup;
			fault_load <= next_fault_load;
		end
	end

	assign s_axi_awready_o = ~aw_hold;
	assign s_axi_wready_o  = ~w_hold;
	assign s_axi_bvalid_o  = bvalid;
	assign s_axi_bresp_o   = bresp;
	assign s_axi_arready_o = ~rvalid;
	assign s_axi_rvalid_o  = rvalid;
	assign s_axi_rresp_o   = rresp;
	assign s_axi_rdata_o   = rdata;

	// A channel under retry runs only in its test window, never with a ground or supply short
	logic amp_live, retry_on;
	assign amp_live    = amp_st != AMP_OFF;
	assign retry_on    = retry_cnt >= 32'(RETRY_CYCLES);
	assign ch_enable_o = amp_live ? (~ch_off | (retry_ch & ~sw_dis & ~fault_gnd & ~fault_sup
		& {NUM_CH{retry_on}})) : '0;

	// Efficiency only while fully running, never during ramps or low supply
	assign eff_mode_o       = (amp_st == AMP_RUN) && !low10_s &&
		(legacy || ctrl[EFF_EN_POS]);
	assign eff_four_ch_o    = legacy | ctrl[FOUR_CH_POS];
	assign eff_level_4ohm_o = ~legacy & ctrl[LOAD_4OHM_POS];
	assign eff_switch_closed_o = eff_mode_o ? ~above_s : '0;

	logic short_any;
	assign short_any = (fault_gnd | fault_sup | fault_load) != '0;
	assign fault_indicator_pin_o    = 1'b0;
	assign fault_indicator_pin_oe_o = (~legacy & por_flag) |
		((legacy | ~ctrl[FAULT_INDICATOR_PIN_SEL_POS]) & short_any);

	eff_gate_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
		(amp_st != AMP_RUN || low10_s) |-> !eff_mode_o) else $error("efficiency outside run");
	eff_low_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
		low10_s |-> !eff_mode_o) else $error("efficiency at low supply");
	legacy_mode_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
		legacy |-> (eff_four_ch_o && !eff_level_4ohm_o)) else $error("legacy mode wrong");
	por_clear_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
		(por_s && !legacy) |=> (ctrl == CTRL_RST && por_flag)) else $error("por not applied");
	por_pin_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
		(por_flag && !legacy) |-> fault_indicator_pin_oe_o) else $error("indicator not low");
	short_pin_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
		(short_any && !ctrl[FAULT_INDICATOR_PIN_SEL_POS]) |-> fault_indicator_pin_oe_o)
		else $error("short not shown");
	hold_off_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
		(sgnd_s | ssup_s) != '0 |=> ((ch_enable_o & $past(sgnd_s | ssup_s)) == '0))
		else $error("shorted channel enabled");
	one_retry_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
		$onehot0(retry_ch)) else $error("parallel retries");
	retry_wait_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
		(retry_ch != '0 && !retry_on) |-> (ch_enable_o & retry_ch) == '0)
		else $error("retry before interval");
	dis_off_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
		$past(sw_dis) == sw_dis |-> (ch_enable_o & sw_dis) == '0 || $past(srst_i))
		else $error("disabled channel on");
	switch_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
		(eff_switch_closed_o & above_s) == '0) else $error("switch closed above half");
endmodule // amp_mode_fault_sequencer

// ===== testbench/mcu_axi_master.sv
// Host microcontroller model speaking AXI4-Lite to the sequencer registers
`timescale 1ns/1ps
module mcu_axi_master
(
	input  wire logic        clk_i,
	output logic [7:0]       awaddr_o,
	output logic             awvalid_o,
	input  wire logic        awready_i,
	output logic [31:0]      wdata_o,
	output logic [3:0]       wstrb_o,
	output logic             wvalid_o,
	input  wire logic        wready_i,
	input  wire logic        bvalid_i,
	output logic             bready_o,
	output logic [7:0]       araddr_o,
	output logic             arvalid_o,
	input  wire logic        arready_i,
	input  wire logic [31:0] rdata_i,
	input  wire logic [1:0]  rresp_i,
	input  wire logic        rvalid_i,
	output logic             rready_o
);
	initial
	begin
		{awaddr_o, awvalid_o, wdata_o, wvalid_o, bready_o} = '0;
		{araddr_o, arvalid_o, rready_o} = '0;
		wstrb_o = 4'hF;
	end

	// Address and data leave together, each released once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		awaddr_o  <= a;
		wdata_o   <= d;
		awvalid_o <= 1'b1;
		wvalid_o  <= 1'b1;
		bready_o  <= 1'b1;
		do
		begin
			@(posedge clk_i);
			if (awready_i)
				awvalid_o <= 1'b0;
			if (wready_i)
				wvalid_o <= 1'b0;
		end
		while (!bvalid_i);
		bready_o <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk_i);
		araddr_o  <= a;
		arvalid_o <= 1'b1;
		rready_o  <= 1'b1;
		do
		begin
			@(posedge clk_i);
			if (arready_i)
				arvalid_o <= 1'b0;
		end
		while (!rvalid_i);
		d = rdata_i;
		r = rresp_i;
		rready_o <= 1'b0;
	endtask
endmodule // mcu_axi_master

// ===== testbench/tb_amp_mode_fault_sequencer.sv
// Self-checking bench for the amplifier mode and fault sequencer
`timescale 1ns/1ps
module tb_amp_mode_fault_sequencer;
	import amp_seq_pkg::*;
	localparam int RETRY = 20;
	typedef struct packed {
		logic [31:0] ctrl;
		logic        lo10;
		logic [2:0]  exp;
		logic [2:0]  msk;
	} row_t;
	// Expected {eff, four_ch, 4 ohm}; masked bits are unspecified while off
	row_t rows [5] = '{
		'{32'h0000_0003, 1'b0, 3'h4, 3'h7},
		'{32'h0000_0007, 1'b0, 3'h6, 3'h7},
		'{32'h0000_000F, 1'b0, 3'h7, 3'h7},
		'{32'h0000_0001, 1'b0, 3'h0, 3'h4},
		'{32'h0000_000B, 1'b1, 3'h0, 3'h4}};
	logic        clk = 1'b0;
	logic        srst = 1'b1;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, d;
	logic [3:0]  wstrb, ch_en, sw;
	logic [1:0]  bresp, rresp, r;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready, eff, four, lvl, pin, oe;
	logic        por = 1'b1, address_select_pin = 1'b1, stby = 1'b0, lo6 = 1'b0, lo10 = 1'b0;
	logic [3:0]  above = 4'h5, sg = 4'h0, ss = 4'h0, sl = 4'h0;
	int          n_mismatch = 0, cmp_count = 0, cyc = 0;
	int          both, n0, first, rise, gap, t0, bad;

	always #50 clk = ~clk;

	amp_mode_fault_sequencer #(.RETRY_CYCLES(RETRY), .RAMP_CYCLES(4)) dut (
		.sys_clk_i(clk), .srst_i(srst), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
		.s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb),
		.s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
		.s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready), .s_axi_araddr_i(araddr),
		.s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
		.s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
		.por_i(por), .address_select_pin_i(address_select_pin), .standby_control_pin_i(stby),
		.supply_below_6v_i(lo6), .supply_below_10v_i(lo10), .out_above_half_i(above),
		.short_gnd_i(sg), .short_sup_i(ss), .short_load_i(sl), .ch_enable_o(ch_en),
		.eff_mode_o(eff), .eff_four_ch_o(four), .eff_level_4ohm_o(lvl),
		.eff_switch_closed_o(sw), .fault_indicator_pin_o(pin), .fault_indicator_pin_oe_o(oe));

	mcu_axi_master mcu (
		.clk_i(clk), .awaddr_o(awaddr), .awvalid_o(awvalid), .awready_i(awready),
		.wdata_o(wdata), .wstrb_o(wstrb), .wvalid_o(wvalid), .wready_i(wready),
		.bvalid_i(bvalid), .bready_o(bready), .araddr_o(araddr), .arvalid_o(arvalid),
		.arready_i(arready), .rdata_i(rdata), .rresp_i(rresp), .rvalid_i(rvalid),
		.rready_o(rready));

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic wait_cyc(input int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic summarize();
		if (n_mismatch == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// Full reset between fault scenarios so latched shorts cannot leak across
	task automatic power_up(input logic [31:0] c);
		srst <= 1'b1;
		wait_cyc(5);
		srst <= 1'b0;
		wait_cyc(3);
		mcu.wr(CTRL_OFS, c);
		wait_cyc(20);
	endtask

	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			n_mismatch++;
			summarize();
		end
	end

	initial
	begin
		wait_cyc(5);
		srst <= 1'b0;
		por  <= 1'b0;
		wait_cyc(5);
		mcu.rd(STAT_OFS, d, r);
		chk("por_flag", 32'h1, {31'h0, d[0]});
		chk("ch_en", 32'h0, {28'h0, ch_en});
		chk("oe", 32'h1, {31'h0, oe});
		mcu.wr(CTRL_OFS, 32'h0000_000F);
		repeat (3)
		begin
			@(posedge clk);
			chk("eff_start", 32'h0, {31'h0, eff});
		end
		wait_cyc(20);
		mcu.rd(STAT_OFS, d, r);
		chk("por_flag", 32'h0, {31'h0, d[0]});
		chk("oe", 32'h0, {31'h0, oe});
		chk("ch_en", 32'hF, {28'h0, ch_en});
		chk("eff_run", 32'h1, {31'h0, eff});
		chk("stat", 32'h1E, {26'h0, d[5:0]});
		mcu.wr(CTRL_OFS, 32'h0000_000E);
		wait_cyc(2);
		chk("eff_stop", 32'h0, {31'h0, eff});
		wait_cyc(20);
		foreach (rows[i])
		begin
			lo10 <= rows[i].lo10;
			mcu.wr(CTRL_OFS, rows[i].ctrl);
			wait_cyc(14);
			chk("eff", {29'h0, rows[i].exp & rows[i].msk}, {29'h0, {eff, four, lvl} & rows[i].msk});
			if (rows[i].exp[2])
				chk("switch", 32'hA, {28'h0, sw});
		end
		mcu.rd(8'h0C, d, r);
		chk("unmapped", {30'h0, RESP_SLVERR}, {30'h0, r});
		chk("unmapped_data", 32'h0, d);
		mcu.wr(8'h0C, 32'h0000_0000);
		chk("unmapped_resp", {30'h0, RESP_SLVERR}, {30'h0, bresp});
		chk("pin", 32'h0, {31'h0, pin});
		por <= 1'b1;
		wait_cyc(5);
		por <= 1'b0;
		mcu.rd(CTRL_OFS, d, r);
		chk("ctrl_por", CTRL_RST, d);
		chk("oe_por", 32'h1, {31'h0, oe});
		power_up(32'h0000_0001);
		sg <= 4'h2;
		ss <= 4'h8;
		wait_cyc(8);
		chk("ch_en_short", 32'h5, {28'h0, ch_en});
		chk("oe_short", 32'h1, {31'h0, oe});
		mcu.rd(FAULT_OFS, d, r);
		chk("fault", 32'h0000_0802, d);
		bad = 0;
		repeat (40)
		begin
			@(posedge clk);
			bad += int'(ch_en[1] | ch_en[3]);
		end
		chk("no_restart", 32'h0, bad);
		sg <= 4'h0;
		ss <= 4'h0;
		power_up(32'h0000_0001);
		sl <= 4'h5;
		wait_cyc(5);
		{both, bad, first, rise, t0} = {0, 0, 0, 0, -1};
		gap = 1000;
		for (int k = 0; k < 120; k++)
		begin
			@(posedge clk);
			both += int'(ch_en[0] & ch_en[2]);
			bad += int'(!(ch_en[1] & ch_en[3]));
			if (first == 0 && ch_en[0])
				first = 1;
			else if (first == 0 && ch_en[2])
				first = 3;
			if (ch_en[0] && k > t0 + 1)
			begin
				if (t0 >= 0 && k - t0 < gap)
					gap = k - t0;
				rise++;
			end
			if (ch_en[0])
				t0 = k;
		end
		chk("one_by_one", 32'h0, both);
		chk("others_run", 32'h0, bad);
		chk("first_retry", 32'h1, first);
		chk("retries", 32'h1, {31'h0, rise >= 2});
		chk("retry_gap", 32'h1, {31'h0, gap >= RETRY});
		mcu.wr(CTRL_OFS, 32'h0000_0501);
		wait_cyc(5);
		bad = 0;
		repeat (60)
		begin
			@(posedge clk);
			bad += int'(ch_en[0] | ch_en[2]);
		end
		chk("disabled", 32'h0, bad);
		sl    <= 4'h0;
		address_select_pin <= 1'b0;
		stby  <= 1'b1;
		srst  <= 1'b1;
		wait_cyc(5);
		srst <= 1'b0;
		wait_cyc(25);
		chk("legacy", 32'h6, {29'h0, 1'b1, four, lvl});
		chk("legacy_on", 32'hF, {28'h0, ch_en});
		lo6 <= 1'b1;
		wait_cyc(10);
		chk("low_off", 32'h0, {28'h0, ch_en});
		lo6 <= 1'b0;
		wait_cyc(25);
		chk("restart", 32'hF, {28'h0, ch_en});
		summarize();
	end
endmodule // tb_amp_mode_fault_sequencer
